// File: logic/tsr_link.sv
// Serial slave of the readout block, clocked by the host's serial clock.
// Assumes an open-drain data wire resolved outside and a snapshot stable during frames.
`timescale 1ns/1ns
`include "tsr_defines.svh"

module tsr_link #(
    parameter logic [2:0] ADDR_LOW = `TSR_ADDR_LOW_DEF
) (
    // Link clock, reset and pins
    input  wire logic             scl_in,
    input  wire logic             rst_in,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe_out,
    // Core side
    input  tsr_pkg::tsr_regs_t    regs_in,
    output logic                  standby_out,
    output logic                  busy_out
);
    import tsr_pkg::*;

    // ======================================================================
    // Frame edges, caught on the data wire while the clock is high.
    // The serial clock stops outside frames, so these flops use an
    // asynchronous clear; they are stable for a half clock before use.
    // A repeated START must keep the frame open, so busy is not a plain
    // toggle pair: START makes the open mark differ from the stop mark,
    // and STOP copies the open mark, which closes the frame.
    logic         start_tgl_ff, stop_tgl_ff, nxt_start_tgl, nxt_stop_tgl;
    logic         open_ff, nxt_open;

    always_comb begin
        nxt_start_tgl = scl_in ? ~start_tgl_ff : start_tgl_ff;
        nxt_open      = scl_in ? ~stop_tgl_ff : open_ff;
        nxt_stop_tgl  = scl_in ? open_ff : stop_tgl_ff;
    end

    always_ff @(negedge sda_in or posedge rst_in) begin
        if (rst_in) begin
            start_tgl_ff <= 1'b0;
            open_ff      <= 1'b0;
        end else begin
            start_tgl_ff <= nxt_start_tgl;
            open_ff      <= nxt_open;
        end
    end

    always_ff @(posedge sda_in or posedge rst_in) begin
        if (rst_in) stop_tgl_ff <= 1'b0;
        else        stop_tgl_ff <= nxt_stop_tgl;
    end

    assign busy_out = open_ff ^ stop_tgl_ff;

    // ======================================================================
    // Byte engine, sampling on the rising serial clock
    tsr_link_st_t st_ff, nxt_st;
    logic [2:0]   cnt_ff, nxt_cnt;
    logic [7:0]   shift_ff, nxt_shift, tx_ff, nxt_tx, byte_w;
    logic         seen_ff, nxt_seen, rw_ff, nxt_rw, ptr_ff, nxt_ptr;
    logic         stby_ff, nxt_stby, start_w;

    assign start_w = start_tgl_ff != seen_ff;
    assign byte_w  = {shift_ff[6:0], sda_in};

    always_comb begin
        nxt_st    = st_ff;
        nxt_cnt   = cnt_ff + 3'h1;
        nxt_shift = shift_ff;
        nxt_tx    = tx_ff;
        nxt_rw    = rw_ff;
        nxt_ptr   = ptr_ff;
        nxt_stby  = stby_ff;
        nxt_seen  = start_tgl_ff;
        if (start_w) begin
            nxt_st    = st_addr;
            nxt_cnt   = 3'h1;
            nxt_shift = {7'h00, sda_in};
        end else begin
            unique case (st_ff)
                st_addr: begin
                    nxt_shift = byte_w;
                    if (cnt_ff == 3'h7) begin
                        if (byte_w[7:1] == {`TSR_ADDR_HI, ADDR_LOW}) begin
                            nxt_rw = byte_w[0];
                            nxt_st = st_ack_addr;
                        end else begin
                            nxt_st = st_ignore;
                        end
                    end
                end
                st_ack_addr: begin
                    nxt_cnt = 3'h0;
                    if (rw_ff) begin
                        nxt_st = st_rdata;
                        nxt_tx = ptr_ff ? regs_in.cfg : regs_in.temp;
                    end else begin
                        nxt_st = st_cmd;
                    end
                end
                st_cmd: begin
                    nxt_shift = byte_w;
                    if (cnt_ff == 3'h7) begin
                        nxt_st = st_ack_cmd;
                        if (byte_w == `TSR_CMD_TEMP)     nxt_ptr = 1'b0;
                        else if (byte_w == `TSR_CMD_CFG) nxt_ptr = 1'b1;
                        else                             nxt_st  = st_ignore;
                    end
                end
                st_ack_cmd: begin
                    nxt_cnt = 3'h0;
                    nxt_st  = st_wdata;
                end
                st_wdata: begin
                    nxt_shift = byte_w;
                    if (cnt_ff == 3'h7) begin
                        nxt_st = st_ack_wdata;
                        // Writes aimed at the temperature result are dropped.
                        if (ptr_ff) nxt_stby = byte_w[`TSR_CFG_STBY_BIT];
                    end
                end
                st_ack_wdata: nxt_st = st_ignore;
                st_rdata: begin
                    nxt_tx = {tx_ff[6:0], 1'b0};
                    if (cnt_ff == 3'h7) nxt_st = st_ack_rdata;
                end
                st_ack_rdata: begin
                    nxt_cnt = 3'h0;
                    if (!sda_in) begin
                        nxt_st = st_rdata;
                        nxt_tx = ptr_ff ? regs_in.cfg : regs_in.temp;
                    end else begin
                        nxt_st = st_ignore;
                    end
                end
                st_idle, st_ignore: nxt_cnt = cnt_ff;
                default: nxt_st = st_idle;
            endcase
        end
    end

    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff    <= st_idle;
            cnt_ff   <= 3'h0;
            shift_ff <= 8'h00;
            tx_ff    <= 8'h00;
            rw_ff    <= 1'b0;
            ptr_ff   <= 1'b0;
            stby_ff  <= 1'b0;
            seen_ff  <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            cnt_ff   <= nxt_cnt;
            shift_ff <= nxt_shift;
            tx_ff    <= nxt_tx;
            rw_ff    <= nxt_rw;
            ptr_ff   <= nxt_ptr;
            stby_ff  <= nxt_stby;
            seen_ff  <= nxt_seen;
        end
    end

    assign standby_out = stby_ff;

    // ======================================================================
    // Pin drive, changed on the falling serial clock
    logic oe_ff, nxt_oe, lvl_ff;

    always_comb begin
        nxt_oe = (st_ff == st_ack_addr) || (st_ff == st_ack_cmd) ||
                 (st_ff == st_ack_wdata) || ((st_ff == st_rdata) && !tx_ff[7]);
    end

    always_ff @(negedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            oe_ff  <= 1'b0;
            lvl_ff <= 1'b0;
        end else begin
            oe_ff  <= nxt_oe;
            lvl_ff <= 1'b0;
        end
    end

    assign sda_oe_out = oe_ff;
    assign sda_out    = lvl_ff;

    // ======================================================================
    // Checks
    a_addr_mismatch: assert property (@(posedge scl_in) disable iff (rst_in)
        (st_ff == st_addr && cnt_ff == 3'h7 && !start_w &&
         byte_w[7:1] != {`TSR_ADDR_HI, ADDR_LOW}) |=> (st_ff == st_ignore) [*2])
        else $error("foreign address was not ignored");

    a_read_source: assert property (@(posedge scl_in) disable iff (rst_in)
        (st_ff == st_ack_addr && rw_ff && !start_w) |=>
        (tx_ff == ($past(ptr_ff) ? regs_in.cfg : regs_in.temp)))
        else $error("read byte not taken from the selected register");

    a_temp_nowrite: assert property (@(posedge scl_in) disable iff (rst_in)
        (st_ff == st_wdata && !ptr_ff) |=> $stable(stby_ff))
        else $error("write to the temperature result changed state");
endmodule

// File: logic/tsr_defines.svh
// Constants of the temperature readout block: bus address, commands, fields, encodings.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

// ==========================================================================
// Serial address and command codes
`define TSR_ADDR_HI        4'h9
`define TSR_ADDR_LOW_DEF   3'h5
`define TSR_CMD_TEMP       8'h00
`define TSR_CMD_CFG        8'h01

// ==========================================================================
// Register layout and reset values
`define TSR_REG_W          8
`define TSR_REG_RST        8'h00
`define TSR_CFG_STBY_BIT   7
`define TSR_CFG_RDY_BIT    6
`define TSR_CFG_RSVD_ZERO  6'h00

// ==========================================================================
// Raw conversion word: signed, two fraction bits (quarter degrees)
`define TSR_RAW_W          12
`define TSR_FRAC_W         2
`define TSR_INT_W          10
`define TSR_INT_MAX        10'sh07F
`define TSR_INT_MIN        10'sh380
`define TSR_TEMP_MAX       8'h7F
`define TSR_TEMP_MIN       8'h80

`endif

// File: logic/tsr_pkg.sv
// Types shared by the readout core and its serial link.
// Assumes nothing beyond the defines header.
package tsr_pkg;

    // ======================================================================
    // Register snapshot handed from the core to the link
    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] cfg;
    } tsr_regs_t;

    // ======================================================================
    // Link byte-level states
    typedef enum logic [3:0] {
        st_idle, st_addr, st_ack_addr, st_cmd, st_ack_cmd,
        st_wdata, st_ack_wdata, st_rdata, st_ack_rdata, st_ignore
    } tsr_link_st_t;

endpackage

// File: logic/tsr_top.sv
// Readout core of a small digital temperature sensor with its serial slave.
// Assumes conversion results arrive on clk_in and the host clocks the link.
//
// Contract
// - Temperature result is eight bits, readable only; host writes never change it.
// - Result is two's-complement whole degrees; zero degrees reads all zeros.
// - Temperatures at or above +127 read as the largest positive code.
// - Fractions round toward negative infinity, so -0.25 reads as -1.
// - All registers are eight bits and reset to all zeros.
// - A new result loads into the temperature register in the same cycle that ready is set; ready stays high across later results.
// - Results refresh after every conversion outside standby without any host action.
// - Slave address is 1001 plus a fixed three-bit variant, default 101.
// - Command 00h selects the temperature, 01h selects the configuration register.
// - Config bit 7 standby select, bit 6 ready flag, bits 5-0 zero.
// - Ready flag clears at power-up and whenever standby select is set.
`timescale 1ns/1ns
`include "tsr_defines.svh"

module tsr_top #(
    parameter logic [2:0] ADDR_LOW = `TSR_ADDR_LOW_DEF
) (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    // Serial link pins
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe_out,
    // Converter side
    input  wire logic                         conv_done_in,
    input  wire logic signed [`TSR_RAW_W-1:0] conv_raw_in,
    output logic                              standby_out,
    output logic                              data_ready_out
);
    import tsr_pkg::*;

    // ======================================================================
    // Serial slave
    tsr_regs_t shadow_ff, nxt_shadow;
    logic      link_stby, link_busy;

    tsr_link #(
        .ADDR_LOW   (ADDR_LOW)
    ) u_link (
        .scl_in     (scl_in),
        .rst_in     (rst_in),
        .sda_in     (sda_in),
        .sda_out    (sda_out),
        .sda_oe_out (sda_oe_out),
        .regs_in    (shadow_ff),
        .standby_out(link_stby),
        .busy_out   (link_busy)
    );

    // ======================================================================
    // Level crossings from the link into clk_in
    logic stby_s1_ff, stby_s2_ff, busy_s1_ff, busy_s2_ff;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stby_s1_ff <= 1'b0;
            stby_s2_ff <= 1'b0;
            busy_s1_ff <= 1'b0;
            busy_s2_ff <= 1'b0;
        end else begin
            stby_s1_ff <= link_stby;
            stby_s2_ff <= stby_s1_ff;
            busy_s1_ff <= link_busy;
            busy_s2_ff <= busy_s1_ff;
        end
    end

    // ======================================================================
    // Encoding: the integer part of a two's-complement word is already the
    // floor, so a part-select rounds negative fractions downward.
    logic signed [`TSR_INT_W-1:0] int_w;
    logic        [7:0]            enc_w;

    always_comb begin
        int_w = conv_raw_in[`TSR_RAW_W-1:`TSR_FRAC_W];
        if (int_w > `TSR_INT_MAX)      enc_w = `TSR_TEMP_MAX;
        else if (int_w < `TSR_INT_MIN) enc_w = `TSR_TEMP_MIN;
        else                           enc_w = int_w[7:0];
    end

    // ======================================================================
    // Result and ready flag
    logic [7:0] temp_ff, nxt_temp, cfg_w;
    logic       ready_ff, nxt_ready;

    always_comb begin
        nxt_temp  = temp_ff;
        nxt_ready = ready_ff;
        if (stby_s2_ff) begin
            nxt_ready = 1'b0;
        end else if (conv_done_in) begin
            nxt_temp  = enc_w;
            nxt_ready = 1'b1;
        end
    end

    assign cfg_w = {stby_s2_ff, ready_ff, `TSR_CFG_RSVD_ZERO};

    // The snapshot seen by the link freezes for a whole frame, so a byte
    // never tears; a result that lands mid-frame shows in the next frame.
    always_comb begin
        nxt_shadow = shadow_ff;
        if (!busy_s2_ff) begin
            nxt_shadow.temp = temp_ff;
            nxt_shadow.cfg  = cfg_w;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            temp_ff   <= `TSR_REG_RST;
            ready_ff  <= 1'b0;
            shadow_ff <= {`TSR_REG_RST, `TSR_REG_RST};
        end else begin
            temp_ff   <= nxt_temp;
            ready_ff  <= nxt_ready;
            shadow_ff <= nxt_shadow;
        end
    end

    assign standby_out    = stby_s2_ff;
    assign data_ready_out = ready_ff;

    // ======================================================================
    // Checks
    a_sat_high: assert property (@(posedge clk_in) disable iff (rst_in)
        (conv_done_in && !stby_s2_ff && conv_raw_in >= 12'sh1FC) |=>
        (temp_ff == `TSR_TEMP_MAX))
        else $error("hot reading did not saturate");

    a_floor_neg: assert property (@(posedge clk_in) disable iff (rst_in)
        (conv_done_in && !stby_s2_ff && conv_raw_in == 12'shFFF) |=>
        (temp_ff == 8'hFF))
        else $error("minus a quarter degree did not read as minus one");

    a_load_ready: assert property (@(posedge clk_in) disable iff (rst_in)
        (conv_done_in && !stby_s2_ff) |=> (ready_ff && temp_ff == $past(enc_w)))
        else $error("result and ready flag not set together");

    a_stby_clears: assert property (@(posedge clk_in) disable iff (rst_in)
        stby_s2_ff |=> !ready_ff)
        else $error("ready flag survived standby");

    a_temp_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        (!conv_done_in || stby_s2_ff) |=> ($stable(temp_ff) && !$rose(ready_ff)))
        else $error("result or ready changed without a conversion");

    a_cfg_rsvd: assert property (@(posedge clk_in) disable iff (rst_in)
        shadow_ff.cfg[5:0] == `TSR_CFG_RSVD_ZERO)
        else $error("reserved configuration bits not zero");

    a_shadow_frozen: assert property (@(posedge clk_in) disable iff (rst_in)
        (busy_s2_ff && $past(busy_s2_ff)) |-> $stable(shadow_ff))
        else $error("snapshot changed during a frame");
endmodule

// File: dv/tsr_host.sv
// Host model of the serial link: a bit-level bus master driven by task calls.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns

module tsr_host (
    // Serial pins
    output logic      scl_out,
    output logic      sda_low_out,
    input  wire logic sda_in
);
    // A quarter of the 80 ns serial period.
    localparam int QTR = 20;

    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    // ======================================================================
    // Frame conditions
    // Serves as START and repeated START; the clock stands high between frames.
    task automatic start_cond();
        sda_low_out = 1'b0;
        #QTR;
        scl_out = 1'b1;
        #QTR;
        sda_low_out = 1'b1;
        #QTR;
        scl_out = 1'b0;
        #QTR;
    endtask

    task automatic stop_cond();
        sda_low_out = 1'b1;
        #QTR;
        scl_out = 1'b1;
        #QTR;
        sda_low_out = 1'b0;
        #(2 * QTR);
    endtask

    // ======================================================================
    // Bits and bytes, MSB first; data changes only while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        sda_low_out = ~b;
        #QTR;
        scl_out = 1'b1;
        #QTR;
        s = sda_in;
        #QTR;
        scl_out = 1'b0;
        #QTR;
    endtask

    // A read passes tx of all ones so the wire is released to the device.
    task automatic byte_xfer(input logic [7:0] tx, input logic ack_tx,
                             output logic [7:0] rx, output logic ack_lvl);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], rx[i]);
        end
        clk_bit(ack_tx, ack_lvl);
        sda_low_out = 1'b0;
    endtask
endmodule

// File: dv/tsr_top_tb.sv
// Self-checking bench of the readout block with a host model on the link.
// Assumes the design files and the defines header are compiled first.
`timescale 1ns/1ns
`include "tsr_defines.svh"

module tsr_top_tb;
    import tsr_pkg::*;
    localparam logic [2:0] ADDR_LOW = `TSR_ADDR_LOW_DEF;
    logic                         clk_in, rst_in, conv_done_in, scl_w, host_low, sda_w;
    logic                         sda_out, sda_oe_out, standby_out, data_ready_out;
    logic signed [`TSR_RAW_W-1:0] conv_raw_in;
    logic [31:0]                  rnd;
    logic [7:0]                   d, last_t;
    logic [11:0]                  raw;
    logic [11:0]                  corner [8];
    int                           errors, checks_done, cycles;

    assign sda_w = (host_low | (sda_oe_out & ~sda_out)) ? 1'b0 : 1'b1;

    tsr_top #(.ADDR_LOW(ADDR_LOW)) tsr_top_i (
        .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_out(sda_oe_out), .conv_done_in(conv_done_in),
        .conv_raw_in(conv_raw_in), .standby_out(standby_out),
        .data_ready_out(data_ready_out)
    );
    tsr_host tsr_host_i (.scl_out(scl_w), .sda_low_out(host_low), .sda_in(sda_w));

    initial clk_in = 1'b0;
    always #20 clk_in = ~clk_in;

    // ======================================================================
    // Reporting
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // The hang guard: a run that outlives its cycle budget fails.
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles > 100000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ======================================================================
    // Expectations and random source
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Floor division by four, then clamp to the eight-bit signed range.
    function automatic logic [7:0] exp_temp(input logic [11:0] r);
        logic signed [9:0] t;
        t = 10'(signed'(r) >>> 2);
        if (t > 10'sd127) return 8'h7F;
        if (t < -10'sd128) return 8'h80;
        return t[7:0];
    endfunction

    // ======================================================================
    // Link transactions; the core gets a few cycles after each frame
    task automatic frame_end();
        tsr_host_i.stop_cond();
        repeat (4) @(posedge clk_in);
    endtask

    task automatic open_frame(input logic rd);
        logic [7:0] rx;
        logic       ak;
        #3;
        tsr_host_i.start_cond();
        tsr_host_i.byte_xfer({`TSR_ADDR_HI, ADDR_LOW, rd}, 1'b1, rx, ak);
        check({7'h00, ak}, 8'h00);
    endtask

    task automatic write_reg(input logic [7:0] cmd, input logic [7:0] v, input logic ok);
        logic [7:0] rx;
        logic       ak;
        open_frame(1'b0);
        tsr_host_i.byte_xfer(cmd, 1'b1, rx, ak);
        check({7'h00, ak}, {7'h00, ~ok});
        if (ok) begin
            tsr_host_i.byte_xfer(v, 1'b1, rx, ak);
            check({7'h00, ak}, 8'h00);
        end
        frame_end();
    endtask

    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] v);
        logic [7:0] rx;
        logic       ak;
        open_frame(1'b0);
        tsr_host_i.byte_xfer(cmd, 1'b1, rx, ak);
        tsr_host_i.start_cond();
        tsr_host_i.byte_xfer({`TSR_ADDR_HI, ADDR_LOW, 1'b1}, 1'b1, rx, ak);
        tsr_host_i.byte_xfer(8'hFF, 1'b1, v, ak);
        frame_end();
    endtask

    task automatic recv(output logic [7:0] v);
        logic ak;
        open_frame(1'b1);
        tsr_host_i.byte_xfer(8'hFF, 1'b1, v, ak);
        frame_end();
    endtask

    task automatic conv(input logic [11:0] r);
        @(posedge clk_in);
        conv_done_in <= 1'b1;
        conv_raw_in  <= r;
        @(posedge clk_in);
        conv_done_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        rst_in       = 1'b1;
        conv_done_in = 1'b0;
        conv_raw_in  = '0;
        errors       = 0;
        checks_done  = 0;
        cycles       = 0;
        rnd          = 32'h0000_47dc;
        last_t       = 8'h00;
        corner       = '{12'h208, 12'h1FC, 12'h1FA, 12'h001, 12'hFFF, 12'hF9B, 12'hEFC, 12'h800};
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        check({7'h00, data_ready_out}, 8'h00);
        recv(d);
        check(d, 8'h00);
        read_reg(`TSR_CMD_CFG, d);
        check(d, 8'h00);
        for (int i = 0; i < 16; i++) begin
            rnd = xs(rnd);
            raw = (i < 8) ? corner[i] : rnd[11:0];
            conv(raw);
            check({7'h00, data_ready_out}, 8'h01);
            last_t = exp_temp(raw);
            read_reg(`TSR_CMD_TEMP, d);
            check(d, last_t);
        end
        // Back-to-back results: the later one must win.
        @(posedge clk_in);
        conv_done_in <= 1'b1;
        conv_raw_in  <= 12'h064;
        @(posedge clk_in);
        conv_raw_in  <= 12'hF9C;
        @(posedge clk_in);
        conv_done_in <= 1'b0;
        last_t = exp_temp(12'hF9C);
        recv(d);
        check(d, last_t);
        write_reg(`TSR_CMD_TEMP, 8'h55, 1'b1);
        read_reg(`TSR_CMD_TEMP, d);
        check(d, last_t);
        write_reg(8'h02, 8'h00, 1'b0);
        recv(d);
        check(d, last_t);
        read_reg(`TSR_CMD_CFG, d);
        check(d, 8'h40);
        recv(d);
        check(d, 8'h40);
        write_reg(`TSR_CMD_CFG, 8'hBF, 1'b1);
        check({6'h00, standby_out, data_ready_out}, 8'h02);
        conv(12'h0A0);
        check({7'h00, data_ready_out}, 8'h00);
        read_reg(`TSR_CMD_CFG, d);
        check(d, 8'h80);
        read_reg(`TSR_CMD_TEMP, d);
        check(d, last_t);
        write_reg(`TSR_CMD_CFG, 8'h7F, 1'b1);
        read_reg(`TSR_CMD_CFG, d);
        check(d, 8'h00);
        conv(12'h0A0);
        read_reg(`TSR_CMD_CFG, d);
        check(d, 8'h40);
        recv(d);
        check(d, 8'h40);
        for (int lo = 0; lo < 8; lo++) begin
            if (3'(lo) != ADDR_LOW) begin
                #3;
                tsr_host_i.start_cond();
                tsr_host_i.byte_xfer({`TSR_ADDR_HI, 3'(lo), 1'b1}, 1'b1, d, raw[0]);
                check({7'h00, raw[0]}, 8'h01);
                frame_end();
            end
        end
        read_reg(`TSR_CMD_TEMP, d);
        check(d, 8'h28);
        tally_and_finish();
    end
endmodule
